/* File: design/gwic_ctrl.sv */
// Interrupt request/enable logic with green and sleep mode control.
// Assumes a CPU sequencer on the same clock that acknowledges vectors
// and signals return-from-interrupt; port_zero pins are asynchronous.
//
// Contract
// - Writing 1 to green_entry_bit halts execution and enters green mode.
// - Any green wake clears green_entry_bit in hardware.
// - Green mode keeps system clock and wake-enabled timer running.
// - Green wake on port_zero level change or timer_a wake overflow.
// - After green wake resume in previous normal or slow mode.
// - PWM-only timer overflow never wakes from green mode.
// - Sleep wakes only on port_zero change, always returning to normal.
// - Sleep wake waits 2048 clocks crystal or 8 clocks RC.
// - Green wake adds no stabilisation delay.
// - Five request sources: two timers, converter, two port pins.
// - Pin request waking from sleep stays latched until serviced.
// - Service entry clears global enable; service exit sets it.
// - Taking a request pushes one level and vectors to address 8.
// - Return-from-interrupt ends service and pops the return address.
// - Enable register holds per-source enables, reset to zero.
// - Request register sets each source flag on its event.
// - Timer_a green wake needs its own wake enable bit.
// - Flags set even when their enable is zero, without vectoring.
// - Global enable is stack register bit 7, reset zero.
// - Pin zero edge select: 01 rise, 10 fall, 11 both.
// - Pin one triggers only on falling edges.
`timescale 1ns/1ps
module gwic_ctrl
    import gwic_pkg::*;
#(
    parameter int WAKE_XTAL_CYCLES = WAKE_XTAL_CLKS,
    parameter int WAKE_RC_CYCLES = WAKE_RC_CLKS,
    parameter int CNT_W = 12
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [1:0] port_zero_i,
    input wire gwic_evt_s evt_i,
    input wire logic irq_ack_i,
    input wire logic return_from_irq_i,
    output logic irq_req_o,
    output logic [11:0] vector_addr_o,
    output logic stack_push_o,
    output logic stack_pop_o,
    output logic cpu_run_o,
    output logic slow_mode_o,
    output logic osc_stop_o
);

////////////////////////////////////////////////////////////////////////
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic [1:0] pin_prev_q;
    logic [1:0] pin_snap_q;
    logic [7:0] flags_q;
    logic [7:0] mask_q;
    logic gie_q;
    logic [2:0] stack_ptr_reg_q;
    logic [1:0] edge_sel_q;
    logic sleep_bit_q;
    logic green_entry_bit_q;
    logic slow_q;
    logic tmra_gw_q;
    logic rc_osc_q;
    logic in_service_q;
    gwic_mode_e mode_q;
    logic [CNT_W-1:0] warm_cnt_q;
    logic [7:0] set_vec;
    logic [7:0] wr_mask;
    logic wr_en;
    logic rd_en;
    logic pin_change;
    logic rise0;
    logic fall0;
    logic fall1;
    logic take;

    function automatic logic addr_hit(input logic [11:0] a,
                                      input logic [11:0] r);
        return a == r;
    endfunction

    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && !pwrite_i;
    assign wr_mask = pstrb_i[0] ? 8'hFF : 8'h00;

////////////////////////////////////////////////////////////////////////
    // Two flops before any logic reads the asynchronous pins.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_meta_q <= port_zero_i;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign rise0 = pin_sync_q[0] && !pin_prev_q[0];
    assign fall0 = !pin_sync_q[0] && pin_prev_q[0];
    assign fall1 = !pin_sync_q[1] && pin_prev_q[1];
    // Levels are compared with the snapshot taken at entry, so a change
    // that happened while the core logic was idle still counts.
    assign pin_change = (pin_sync_q != pin_snap_q);

    always_comb begin
        set_vec = '0;
        case (edge_sel_q)
            EDGE_RISE: set_vec[BIT_PIN0] = rise0;
            EDGE_FALL: set_vec[BIT_PIN0] = fall0;
            EDGE_BOTH: set_vec[BIT_PIN0] = rise0 || fall0;
            default: set_vec[BIT_PIN0] = 1'b0;
        endcase
        set_vec[BIT_PIN1] = fall1;
        // Sleep stops the timers and converter entirely.
        if (mode_q != GWIC_SLEEP && mode_q != GWIC_WARM) begin
            set_vec[BIT_TMRA] = evt_i.tmr_a_ovf;
            set_vec[BIT_TMRB] = evt_i.tmr_b_ovf;
            set_vec[BIT_CONV] = evt_i.conv_done;
        end
    end

////////////////////////////////////////////////////////////////////////
    // Flags set regardless of enable; set wins over a same-cycle clear.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_q <= FLAGS_RESET;
        end else if (wr_en && addr_hit(paddr_i, ADDR_IRQ_FLAGS)) begin
            flags_q <= (((flags_q & ~wr_mask) | (pwdata_i[7:0] & wr_mask))
                        | set_vec) & SRC_MASK;
        end else begin
            flags_q <= (flags_q | set_vec) & SRC_MASK;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_q <= MASK_RESET;
        end else if (wr_en && addr_hit(paddr_i, ADDR_IRQ_MASK)) begin
            mask_q <= (mask_q & ~wr_mask) | (pwdata_i[7:0] & wr_mask
                      & SRC_MASK);
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            edge_sel_q <= EDGE_RESET;
            slow_q <= 1'b0;
            tmra_gw_q <= 1'b0;
            rc_osc_q <= 1'b0;
        end else if (wr_en && pstrb_i[0]
                     && addr_hit(paddr_i, ADDR_EDGE_CFG)) begin
            edge_sel_q <= pwdata_i[1:0];
        end else if (wr_en && pstrb_i[0]
                     && addr_hit(paddr_i, ADDR_OSC_MODE)) begin
            slow_q <= pwdata_i[BIT_SLOW];
            tmra_gw_q <= pwdata_i[BIT_TMRA_GW];
            rc_osc_q <= pwdata_i[BIT_RC_OSC];
        end else if (mode_q == GWIC_WARM) begin
            slow_q <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////
    assign take = irq_req_o && irq_ack_i;

    // Global enable and stack pointer; entry and exit override writes.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gie_q <= 1'b0;
            stack_ptr_reg_q <= STACK_PTR_REG_RESET;
            in_service_q <= 1'b0;
        end else if (take) begin
            gie_q <= 1'b0;
            stack_ptr_reg_q <= stack_ptr_reg_q - 3'h1;
            in_service_q <= 1'b1;
        end else if (return_from_irq_i && in_service_q) begin
            gie_q <= 1'b1;
            stack_ptr_reg_q <= stack_ptr_reg_q + 3'h1;
            in_service_q <= 1'b0;
        end else if (wr_en && pstrb_i[0]
                     && addr_hit(paddr_i, ADDR_STACK_PTR)) begin
            gie_q <= pwdata_i[BIT_GIE];
            stack_ptr_reg_q <= pwdata_i[2:0];
        end
    end

    // Only a running core may be vectored.
    assign irq_req_o = gie_q && (mode_q == GWIC_RUN) && !in_service_q
                       && |(flags_q & mask_q);
    assign vector_addr_o = VECTOR_ADDR;
    assign stack_push_o = take;
    assign stack_pop_o = return_from_irq_i && in_service_q;

////////////////////////////////////////////////////////////////////////
    // Mode sequencer.  Sleep wins if both entry bits are written at once.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= GWIC_RUN;
            sleep_bit_q <= 1'b0;
            green_entry_bit_q <= 1'b0;
            warm_cnt_q <= '0;
            pin_snap_q <= '0;
        end else begin
            case (mode_q)
                GWIC_RUN: begin
                    if (wr_en && pstrb_i[0]
                        && addr_hit(paddr_i, ADDR_OSC_MODE)) begin
                        pin_snap_q <= pin_sync_q;
                        if (pwdata_i[BIT_SLEEP]) begin
                            sleep_bit_q <= 1'b1;
                            mode_q <= GWIC_SLEEP;
                        end else if (pwdata_i[BIT_GREEN]) begin
                            green_entry_bit_q <= 1'b1;
                            mode_q <= GWIC_GREEN;
                        end
                    end
                end
                GWIC_GREEN: begin
                    // Pwm-only overflow is ignored; no warm-up applies.
                    if (pin_change || (evt_i.tmr_a_ovf && tmra_gw_q
                        && !evt_i.tmr_a_pwm_only)) begin
                        green_entry_bit_q <= 1'b0;
                        mode_q <= GWIC_RUN;
                    end
                end
                GWIC_SLEEP: begin
                    if (pin_change) begin
                        warm_cnt_q <= rc_osc_q
                            ? CNT_W'(WAKE_RC_CYCLES - 1)
                            : CNT_W'(WAKE_XTAL_CYCLES - 1);
                        mode_q <= GWIC_WARM;
                    end
                end
                GWIC_WARM: begin
                    if (warm_cnt_q == '0) begin
                        sleep_bit_q <= 1'b0;
                        mode_q <= GWIC_RUN;
                    end else begin
                        warm_cnt_q <= warm_cnt_q - 1'b1;
                    end
                end
                default: mode_q <= GWIC_RUN;
            endcase
        end
    end

    assign cpu_run_o = (mode_q == GWIC_RUN);
    assign slow_mode_o = slow_q;
    assign osc_stop_o = (mode_q == GWIC_SLEEP);

////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= '0;
        end else if (rd_en && !penable_i) begin
            prdata_o <= '0;
            if (addr_hit(paddr_i, ADDR_IRQ_FLAGS)) begin
                prdata_o[7:0] <= flags_q;
            end else if (addr_hit(paddr_i, ADDR_IRQ_MASK)) begin
                prdata_o[7:0] <= mask_q;
            end else if (addr_hit(paddr_i, ADDR_STACK_PTR)) begin
                prdata_o[7:0] <= {gie_q, 4'h0, stack_ptr_reg_q};
            end else if (addr_hit(paddr_i, ADDR_OSC_MODE)) begin
                prdata_o[4:0] <= {rc_osc_q, tmra_gw_q, slow_q,
                                  green_entry_bit_q, sleep_bit_q};
            end else if (addr_hit(paddr_i, ADDR_EDGE_CFG)) begin
                prdata_o[1:0] <= edge_sel_q;
            end else if (addr_hit(paddr_i, ADDR_STATUS)) begin
                prdata_o[2:0] <= {in_service_q, mode_q};
            end
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i
        && !(addr_hit(paddr_i, ADDR_IRQ_FLAGS)
        || addr_hit(paddr_i, ADDR_IRQ_MASK)
        || addr_hit(paddr_i, ADDR_STACK_PTR)
        || addr_hit(paddr_i, ADDR_OSC_MODE)
        || addr_hit(paddr_i, ADDR_EDGE_CFG)
        || (addr_hit(paddr_i, ADDR_STATUS) && !pwrite_i));

////////////////////////////////////////////////////////////////////////
    a_green_clears_bit: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        (mode_q == GWIC_GREEN) ##1 (mode_q == GWIC_RUN)
        |-> !green_entry_bit_q) else $error("green bit not cleared");
    a_green_pwm_nowake: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        (mode_q == GWIC_GREEN && !pin_change && !(evt_i.tmr_a_ovf
        && tmra_gw_q && !evt_i.tmr_a_pwm_only)) |=> mode_q == GWIC_GREEN)
        else $error("green left without wake");
    a_sleep_pin_only: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        (mode_q == GWIC_SLEEP && !pin_change) |=> mode_q == GWIC_SLEEP)
        else $error("sleep left without pin change");
    a_rc_warm_len: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        (mode_q == GWIC_SLEEP && pin_change && rc_osc_q)
        |=> (mode_q == GWIC_WARM) [*8] ##1 mode_q == GWIC_RUN)
        else $error("rc warm-up length wrong");
    a_green_no_delay: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        (mode_q == GWIC_GREEN && pin_change) |=> cpu_run_o)
        else $error("green wake delayed");
    a_entry_clears_gie: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        take |=> !gie_q && in_service_q) else $error("gie not cleared");
    a_exit_sets_gie: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        stack_pop_o |=> gie_q && !in_service_q) else $error("gie not set");
    a_flag_kept_take: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        take && !wr_en |=> flags_q == $past(flags_q | set_vec))
        else $error("flags changed on service entry");
    a_req_needs_all: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        irq_req_o |-> gie_q && |(flags_q & mask_q))
        else $error("request without enables");
    a_pin1_falling: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        $fell(pin_sync_q[1]) |=> flags_q[BIT_PIN1])
        else $error("pin one fall missed");
    a_take_pushes_one: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        take |=> stack_ptr_reg_q == $past(stack_ptr_reg_q) - 3'h1)
        else $error("stack not pushed by one level");
    a_event_sets_flag: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        evt_i.tmr_b_ovf && mode_q == GWIC_RUN |=> flags_q[BIT_TMRB])
        else $error("timer b flag not set");
    a_warm_to_normal: assert property (@(posedge mclk_i)
        disable iff (!reset_n_i)
        (mode_q == GWIC_WARM) ##1 (mode_q == GWIC_RUN) |-> !slow_mode_o)
        else $error("sleep wake not in normal mode");
endmodule

/* File: design/gwic_pkg.sv */
// Package for the green/wake interrupt controller.
// Assumes a 25 MHz system clock and a 32-bit APB slave interface.
package gwic_pkg;
    localparam logic [11:0] ADDR_IRQ_FLAGS = 12'h320;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h324;
    localparam logic [11:0] ADDR_STACK_PTR = 12'h37C;
    localparam logic [11:0] ADDR_OSC_MODE = 12'h010;
    localparam logic [11:0] ADDR_EDGE_CFG = 12'h014;
    localparam logic [11:0] ADDR_STATUS = 12'h018;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'hC8;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hC9;
    localparam logic [7:0] IDX_STACK_PTR = 8'hDF;
    localparam int BIT_PIN0 = 0;
    localparam int BIT_PIN1 = 1;
    localparam int BIT_TMRA = 5;
    localparam int BIT_TMRB = 6;
    localparam int BIT_CONV = 7;
    localparam int BIT_GIE = 7;
    localparam int BIT_SLEEP = 0;
    localparam int BIT_GREEN = 1;
    localparam int BIT_SLOW = 2;
    localparam int BIT_TMRA_GW = 3;
    localparam int BIT_RC_OSC = 4;
    localparam logic [7:0] SRC_MASK = 8'hE3;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [2:0] STACK_PTR_REG_RESET = 3'h7;
    localparam logic [1:0] EDGE_RESET = 2'h2;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [11:0] VECTOR_ADDR = 12'h008;
    localparam int WAKE_XTAL_CLKS = 2048;
    localparam int WAKE_RC_CLKS = 8;
    typedef enum logic [1:0] {
        GWIC_RUN = 2'b00,
        GWIC_GREEN = 2'b01,
        GWIC_SLEEP = 2'b10,
        GWIC_WARM = 2'b11
    } gwic_mode_e;
    typedef struct packed {
        logic tmr_a_ovf;
        logic tmr_b_ovf;
        logic conv_done;
        logic tmr_a_pwm_only;
    } gwic_evt_s;
endpackage

/* File: verif/green_wake_interrupt_ctrl_tb.sv */
// Self-checking bench for the green/wake interrupt controller.
// Assumes gwic_pkg and gwic_ctrl; warm-up shortened to XTAL cycles.
`timescale 1ns/1ps
module green_wake_interrupt_ctrl_tb;
    import gwic_pkg::*;
    localparam int XTAL = 16;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq_req_o, stack_push, stack_pop, irq_ack, rti;
    logic cpu_run_o, slow_mode_o, osc_stop_o, ack_en = 1'b1;
    logic [1:0] port = 2'b00;
    logic [11:0] vector_addr_o;
    logic [7:0] pushes, pops;
    gwic_evt_s evt = '0;
    int fails = 0;
    int total_checks = 0;

    always #20 mclk_i = ~mclk_i;

    gwic_ctrl #(.WAKE_XTAL_CYCLES(XTAL)) uut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .port_zero_i(port),
        .evt_i(evt), .irq_ack_i(irq_ack), .return_from_irq_i(rti),
        .irq_req_o(irq_req_o), .vector_addr_o(vector_addr_o),
        .stack_push_o(stack_push), .stack_pop_o(stack_pop),
        .cpu_run_o(cpu_run_o), .slow_mode_o(slow_mode_o),
        .osc_stop_o(osc_stop_o));

    gwic_cpu_model cpu (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .irq_req_i(irq_req_o),
        .ack_en_i(ack_en), .stack_push_i(stack_push),
        .stack_pop_i(stack_pop), .irq_ack_o(irq_ack),
        .return_from_irq_o(rti), .pushes_o(pushes), .pops_o(pops));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic b);
        check(32'(b), 32'h0000_0001);
    endtask

    // Outputs are looked at on the falling edge, clear of the update.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h00_0000, d}, r, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(r, x);
    endtask

    task automatic pulse(input logic [2:0] ev, input logic pw);
        @(posedge mclk_i);
        evt <= {ev, pw};
        @(posedge mclk_i);
        evt <= {3'b000, pw};
    endtask

    task automatic wait_run(output int n);
        n = 0;
        while (cpu_run_o !== 1'b1 && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 200) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic wait_pop(input logic [7:0] p);
        int n;
        n = 0;
        while (pops !== p + 8'h01 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        chk1(n < 100);
        if (n >= 100) begin
            give_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rdc(ADDR_IRQ_FLAGS, 32'h0000_0000);
        rdc(ADDR_IRQ_MASK, 32'h0000_0000);
        rdc(ADDR_STACK_PTR, 32'h0000_0007);
        apb(1'b0, 12'h100, 32'h0000_0000, r, e);
        chk1(e);
        check(r, 32'h0000_0000);
        apb(1'b1, ADDR_STATUS, 32'h0000_0000, r, e);
        chk1(e);
        chk1(cpu_run_o & ~irq_req_o);
        $display("test reset done");
    endtask

    task automatic t_no_enable();
        pulse(3'b010, 1'b0);
        rdc(ADDR_IRQ_FLAGS, 32'h0000_0040);
        chk1(!irq_req_o);
        wr(ADDR_IRQ_MASK, 8'hFF);
        rdc(ADDR_IRQ_MASK, 32'h0000_00E3);
        pulse(3'b001, 1'b0);
        rdc(ADDR_IRQ_FLAGS, 32'h0000_00C0);
        chk1(!irq_req_o);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        rdc(ADDR_IRQ_FLAGS, 32'h0000_0000);
        wr(ADDR_IRQ_MASK, 8'h00);
        $display("test flags without enable done");
    endtask

    task automatic t_vector();
        logic [7:0] p;
        wr(ADDR_IRQ_MASK, 8'h20);
        ack_en <= 1'b0;
        wr(ADDR_STACK_PTR, 8'h87);
        pulse(3'b100, 1'b0);
        tick(3);
        chk1(irq_req_o);
        check(32'(vector_addr_o), 32'h0000_0008);
        p = pushes;
        @(posedge mclk_i);
        ack_en <= 1'b1;
        tick(2);
        check(32'(pushes), 32'(p + 8'h01));
        rdc(ADDR_STACK_PTR, 32'h0000_0006);
        rdc(ADDR_STATUS, 32'h0000_0004);
        rdc(ADDR_IRQ_FLAGS, 32'h0000_0020);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        wait_pop(pops);
        rdc(ADDR_STACK_PTR, 32'h0000_0087);
        wr(ADDR_STACK_PTR, 8'h07);
        wr(ADDR_IRQ_MASK, 8'h00);
        $display("test vector done");
    endtask

    // Pin one rides along with pin zero and must flag on falls only.
    task automatic t_edges();
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_EDGE_CFG, 8'(c));
            wr(ADDR_IRQ_FLAGS, 8'h00);
            @(posedge mclk_i);
            port <= 2'b11;
            tick(5);
            rdc(ADDR_IRQ_FLAGS, 32'(c & 1));
            wr(ADDR_IRQ_FLAGS, 8'h00);
            @(posedge mclk_i);
            port <= 2'b00;
            tick(5);
            rdc(ADDR_IRQ_FLAGS, 32'(2 | (c >> 1)));
        end
        wr(ADDR_IRQ_FLAGS, 8'h00);
        $display("test edges done");
    endtask

    task automatic t_green();
        int n;
        wr(ADDR_OSC_MODE, 8'h0E);
        tick(2);
        chk1(!cpu_run_o);
        rdc(ADDR_STATUS, 32'h0000_0001);
        pulse(3'b110, 1'b1);
        tick(3);
        chk1(!cpu_run_o);
        pulse(3'b100, 1'b0);
        tick(1);
        chk1(cpu_run_o & slow_mode_o);
        rdc(ADDR_OSC_MODE, 32'h0000_000C);
        wr(ADDR_OSC_MODE, 8'h02);
        pulse(3'b100, 1'b0);
        tick(3);
        chk1(!cpu_run_o);
        @(posedge mclk_i);
        port[0] <= 1'b1;
        wait_run(n);
        chk1(n == 4 && !slow_mode_o);
        rdc(ADDR_OSC_MODE, 32'h0000_0000);
        $display("test green done");
    endtask

    task automatic t_sleep();
        int n, w;
        logic [7:0] p;
        for (int k = 0; k < 2; k++) begin
            w = k ? WAKE_RC_CLKS : XTAL;
            if (k == 0) begin
                @(posedge mclk_i);
                port <= 2'b00;
                tick(4);
                wr(ADDR_EDGE_CFG, 8'h01);
                wr(ADDR_IRQ_FLAGS, 8'h00);
                wr(ADDR_IRQ_MASK, 8'h01);
                wr(ADDR_STACK_PTR, 8'h87);
            end
            p = pushes;
            wr(ADDR_OSC_MODE, k ? 8'h11 : 8'h0D);
            tick(2);
            chk1(osc_stop_o & ~cpu_run_o);
            pulse(3'b110, 1'b0);
            tick(2);
            chk1(!cpu_run_o);
            @(posedge mclk_i);
            port[0] <= ~port[0];
            wait_run(n);
            // Two sync flops and one detect cycle precede the warm-up.
            chk1(n == w + 4);
            chk1(!slow_mode_o && !osc_stop_o);
            tick(3);
            check(32'(pushes), 32'(k ? p : p + 8'h01));
            if (k == 0) begin
                wr(ADDR_IRQ_FLAGS, 8'h00);
                wait_pop(p);
            end
        end
        $display("test sleep done");
    endtask

    // Reset taken in green mode must leave the core running and clean.
    task automatic t_midreset();
        wr(ADDR_OSC_MODE, 8'h0E);
        tick(2);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        tick(2);
        chk1(cpu_run_o & ~slow_mode_o & ~osc_stop_o);
        @(posedge mclk_i);
        reset_n_i <= 1'b1;
        tick(1);
        rdc(ADDR_OSC_MODE, 32'h0000_0000);
        rdc(ADDR_STACK_PTR, 32'h0000_0007);
        rdc(ADDR_IRQ_MASK, 32'h0000_0000);
        $display("test mid-run reset done");
    endtask

    initial begin
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        tick(1);
        t_reset();
        t_no_enable();
        t_vector();
        t_edges();
        t_green();
        t_sleep();
        t_midreset();
        give_verdict();
    end
endmodule

/* File: verif/gwic_cpu_model.sv */
// CPU sequencer model facing the green/wake interrupt controller.
// Assumes the controller's clock and reset; counts pushes and pops.
`timescale 1ns/1ps
module gwic_cpu_model #(
    parameter int SERVICE_CYCLES = 24
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic irq_req_i,
    input wire logic ack_en_i,
    input wire logic stack_push_i,
    input wire logic stack_pop_i,
    output logic irq_ack_o,
    output logic return_from_irq_o,
    output logic [7:0] pushes_o,
    output logic [7:0] pops_o
);
    logic busy_q;
    int cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // The vector is taken in the cycle it is shown, so the ack is
    // combinational; ack_en_i lets the bench answer late.
    assign irq_ack_o = irq_req_i & ack_en_i & ~busy_q;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
            return_from_irq_o <= 1'b0;
        end else begin
            return_from_irq_o <= 1'b0;
            if (irq_ack_o) begin
                busy_q <= 1'b1;
                cnt_q <= 0;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 1;
                // Ends the routine only after a vector was taken.
                if (cnt_q == SERVICE_CYCLES - 1) begin
                    return_from_irq_o <= 1'b1;
                    busy_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pushes_o <= 8'h00;
            pops_o <= 8'h00;
        end else begin
            pushes_o <= pushes_o + 8'(stack_push_i);
            pops_o <= pops_o + 8'(stack_pop_i);
        end
    end
endmodule
